// file: rtl/arf_regs.svh
`ifndef ARF_REGS_SVH
`define ARF_REGS_SVH
// Register offsets on the bus
`define ARF_OFF_FLAGS 8'h00
`define ARF_OFF_IP 8'h04
`define ARF_OFF_CTRL 8'h08
`define ARF_OFF_STAT 8'h0C
`define ARF_GPR_PAGE 3'h1
`define ARF_SEL_PAGE 3'h2
`define ARF_SEG_COUNT 3'h6
// Flag bit positions
`define ARF_F_CF 0
`define ARF_F_PF 2
`define ARF_F_AF 4
`define ARF_F_ZF 6
`define ARF_F_SF 7
`define ARF_F_TF 8
`define ARF_F_IF 9
`define ARF_F_DF 10
`define ARF_F_OF 11
`define ARF_F_IO_PRIVILEGE_LEVEL 13:12
`define ARF_F_NT 14
`define ARF_F_RF 16
`define ARF_F_VM 17
`define ARF_F_AC 18
// Flag reset, fixed and writable masks
`define ARF_FLAGS_RST 32'h0000_0002
`define ARF_FLAGS_ONE 32'h0000_0002
`define ARF_FLAGS_LIVE 32'h0007_7FD5
`define ARF_FLAGS_SW 32'h0005_7FD5
// Six status bits that arithmetic rewrites; control bits stay put
`define ARF_FLAGS_ARITH 32'h0000_08D5
// Control and status fields
`define ARF_C_PE 0
`define ARF_C_PG 1
`define ARF_C_AM 2
`define ARF_C_CPL 5:4
`define ARF_S_EPL 1:0
`define ARF_S_ARM 2
// Selector fields
`define ARF_SEL_RPL 1:0
`define ARF_SEL_TI 2
`define ARF_SEL_IDX 15:3
`define ARF_SEG_SHIFT 4
// Reset contents
`define ARF_IP_RST 32'h0000_FFF0
`define ARF_CS_RST 16'hF000
`define ARF_LIM_RST 32'h0000_FFFF
`define ARF_ZERO32 32'h0000_0000
// Fixed register slots and privilege
`define ARF_SP 3'h4
`define ARF_BP 3'h5
`define ARF_SI 3'h6
`define ARF_DI 3'h7
`define ARF_PRIV0 2'h0
`define ARF_OFF16 32'h0000_FFFF
`define ARF_STEP_B 32'h0000_0001
`define ARF_STEP_W 32'h0000_0002
`define ARF_STEP_D 32'h0000_0004
`endif

// file: rtl/arf_pkg.sv
`default_nettype none
package arf_pkg;
   typedef enum logic [2:0] {
      SEG_EXTRA = 3'h0, SEG_CODE = 3'h1, SEG_STACK = 3'h2,
      SEG_DATA = 3'h3, SEG_EXTRA2 = 3'h4, SEG_EXTRA3 = 3'h5
   } arf_seg_t;
   typedef enum logic [1:0] {
      SZ_BLO = 2'h0, SZ_BHI = 2'h1, SZ_W = 2'h2, SZ_D = 2'h3
   } arf_size_t;
   typedef enum logic [1:0] {
      REF_FETCH = 2'h0, REF_STACK = 2'h1, REF_STRDST = 2'h2, REF_DATA = 2'h3
   } arf_ref_t;
   typedef enum logic [1:0] {RUN_IDLE = 2'b01, RUN_ARMED = 2'b10} arf_run_t;
   typedef struct packed {
      arf_run_t run;
      logic [31:0] flags;
      logic [31:0] ip;
      logic [7:0][31:0] gpr;
      logic [5:0][15:0] sel;
      logic [5:0][31:0] base;
      logic [5:0][31:0] lim;
      logic [5:0][7:0] acc;
      logic pe;
      logic pg;
      logic am;
      logic [1:0] current_privilege;
      logic [1:0] effective_privilege;
      logic [31:0] prdata;
      logic [31:0] rdData;
      logic [31:0] linAddr;
      logic xlate;
      logic alignFault;
      logic stepTrap;
      logic intrAck;
      logic debugFault;
      logic ioDeny;
      logic privFault;
   } arf_state_t;
endpackage
`default_nettype wire

// file: rtl/arf_flag_unit.sv
`include "arf_regs.svh"
`default_nettype none
module arf_flag_unit (
   input wire logic sub,
   input wire arf_pkg::arf_size_t size,
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   input wire logic cin,
   output logic [31:0] res,
   output logic [31:0] flagVal
);
   import arf_pkg::*;
   logic [31:0] mask;
   logic [32:0] full;
   int w;
   logic cy;
   // Operands are cut to the operand width so the carry lands at bit w
   always_comb begin
      case (size)
         SZ_D: begin w = 32; mask = 32'hFFFF_FFFF; end
         SZ_W: begin w = 16; mask = 32'h0000_FFFF; end
         default: begin w = 8; mask = 32'h0000_00FF; end
      endcase
      if (sub) begin
         full = {1'b0, a & mask} - {1'b0, b & mask} - {32'h0, cin};
      end else begin
         full = {1'b0, a & mask} + {1'b0, b & mask} + {32'h0, cin};
      end
      res = full[31:0] & mask;
      cy = full[w];
      flagVal = `ARF_ZERO32;
      flagVal[`ARF_F_CF] = cy;
      flagVal[`ARF_F_PF] = ~^res[7:0];
      flagVal[`ARF_F_AF] = a[4] ^ b[4] ^ full[4];
      flagVal[`ARF_F_ZF] = (res == `ARF_ZERO32);
      flagVal[`ARF_F_SF] = res[w-1];
      // Carry into sign bit differs from carry out
      flagVal[`ARF_F_OF] = (a[w-1] ^ b[w-1] ^ full[w-1]) ^ cy;
   end
endmodule // arf_flag_unit
`default_nettype wire

// file: rtl/arf_seg_unit.sv
`include "arf_regs.svh"
`default_nettype none
module arf_seg_unit (
   input wire logic realStyle,
   input wire logic pe,
   input wire logic pg,
   input wire logic addr32,
   input wire logic [15:0] sel,
   input wire logic [31:0] base,
   input wire logic [31:0] offset,
   input wire logic [15:0] loadSel,
   output logic [31:0] linAddr,
   output logic xlate,
   output logic [12:0] descIndex,
   output logic descLocal,
   output logic [1:0] reqPriv
);
   logic [31:0] off;
   // Offset width follows the address size
   always_comb begin
      off = addr32 ? offset : (offset & `ARF_OFF16);
      if (realStyle) begin
         linAddr = (32'(sel) << `ARF_SEG_SHIFT) + off;
      end else begin
         linAddr = base + off;
      end
   end
   // Paging only exists with protection on; real mode is always direct
   assign xlate = pg & pe;
   // Selector split for the descriptor fetch
   assign descIndex = loadSel[`ARF_SEL_IDX];
   assign descLocal = loadSel[`ARF_SEL_TI];
   assign reqPriv = loadSel[`ARF_SEL_RPL];
endmodule // arf_seg_unit
`default_nettype wire

// file: rtl/arf_register_file.sv
`include "arf_regs.svh"
`default_nettype none
module arf_register_file (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic gprWrEn,
   input wire logic [2:0] gprWrIdx,
   input wire arf_pkg::arf_size_t gprWrSize,
   input wire logic [31:0] gprWrData,
   input wire logic [2:0] gprRdIdx,
   input wire arf_pkg::arf_size_t gprRdSize,
   output logic [31:0] gprRdData,
   input wire logic aluValid,
   input wire logic aluSub,
   input wire arf_pkg::arf_size_t aluSize,
   input wire logic [2:0] aluDst,
   input wire logic [31:0] aluA,
   input wire logic [31:0] aluB,
   input wire logic aluUseCarry,
   input wire logic strStep,
   input wire arf_pkg::arf_size_t strSize,
   input wire logic segLoad,
   input wire arf_pkg::arf_seg_t segLoadIdx,
   input wire logic [15:0] segLoadSel,
   input wire logic [31:0] descBase,
   input wire logic [31:0] descLimit,
   input wire logic [7:0] descRights,
   output logic [12:0] descIndex,
   output logic descLocal,
   input wire logic refValid,
   input wire arf_pkg::arf_ref_t refKind,
   input wire arf_pkg::arf_size_t refSize,
   input wire logic [2:0] refBase,
   input wire logic refOverride,
   input wire arf_pkg::arf_seg_t refOverSeg,
   input wire logic [31:0] refOffset,
   input wire logic refAddr32,
   output logic [31:0] linAddr,
   output logic linXlate,
   output logic alignFault,
   input wire logic retire,
   input wire logic [3:0] instrLen,
   input wire logic branch,
   input wire logic [31:0] branchTarget,
   input wire logic vecLoad,
   input wire logic [31:0] vecTarget,
   input wire logic intrReq,
   output logic intrAck,
   output logic stepTrap,
   input wire logic debugReq,
   output logic debugFault,
   input wire logic ioCheck,
   output logic ioDeny,
   input wire logic privOp,
   output logic privFault,
   input wire logic popValid,
   input wire logic iretValid,
   input wire logic [31:0] popData,
   input wire logic taskSwitch,
   input wire logic taskNested,
   input wire logic [31:0] taskFlags,
   output logic [31:0] flags,
   output logic [31:0] ip,
   output logic [1:0] effPriv
);
   import arf_pkg::*;

   arf_state_t s;
   arf_state_t next_s;
   logic [31:0] aluRes;
   logic [31:0] aluFlags;
   logic [31:0] segLin;
   logic segXlate;
   logic [1:0] loadRpl;
   arf_seg_t refSeg;
   logic realStyle;
   logic [1:0] io_privilege_level;

   // Byte registers 4..7 name the high byte of registers 0..3
   function automatic logic [2:0] slotOf(input logic [2:0] idx, input arf_size_t sz);
      slotOf = (sz == SZ_BLO && idx[2]) ? {1'b0, idx[1:0]} : idx;
   endfunction

   function automatic arf_size_t laneOf(input logic [2:0] idx, input arf_size_t sz);
      laneOf = (sz == SZ_BLO && idx[2]) ? SZ_BHI : sz;
   endfunction

   // Merge a narrow write into the old word, upper bytes untouched
   function automatic logic [31:0] mergeIn(input logic [31:0] old, input logic [31:0] d,
                                           input arf_size_t sz);
      case (sz)
         SZ_BLO: mergeIn = {old[31:8], d[7:0]};
         SZ_BHI: mergeIn = {old[31:16], d[7:0], old[7:0]};
         SZ_W: mergeIn = {old[31:16], d[15:0]};
         default: mergeIn = d;
      endcase
   endfunction

   function automatic logic [31:0] pickOut(input logic [31:0] v, input arf_size_t sz);
      case (sz)
         SZ_BLO: pickOut = {24'h0, v[7:0]};
         SZ_BHI: pickOut = {24'h0, v[15:8]};
         SZ_W: pickOut = {16'h0, v[15:0]};
         default: pickOut = v;
      endcase
   endfunction

   function automatic logic [31:0] stepOf(input arf_size_t sz);
      case (sz)
         SZ_D: stepOf = `ARF_STEP_D;
         SZ_W: stepOf = `ARF_STEP_W;
         default: stepOf = `ARF_STEP_B;
      endcase
   endfunction

   // Implied segment per reference kind
   function automatic arf_seg_t segOf(input arf_ref_t k, input logic [2:0] b,
                                      input logic ov, input arf_seg_t os);
      case (k)
         REF_FETCH: segOf = SEG_CODE;
         REF_STACK: segOf = SEG_STACK;
         REF_STRDST: segOf = SEG_EXTRA;
         default: begin
            if (ov) begin
               segOf = os;
            end else if (b == `ARF_SP || b == `ARF_BP) begin
               segOf = SEG_STACK;
            end else begin
               segOf = SEG_DATA;
            end
         end
      endcase
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `ARF_OFF_FLAGS) || (a == `ARF_OFF_IP) || (a == `ARF_OFF_CTRL)
         || (a == `ARF_OFF_STAT) || (a[7:5] == `ARF_GPR_PAGE)
         || (a[7:5] == `ARF_SEL_PAGE && a[4:2] < `ARF_SEG_COUNT);
   endfunction

   assign realStyle = ~s.pe | s.flags[`ARF_F_VM];
   assign io_privilege_level = s.flags[`ARF_F_IO_PRIVILEGE_LEVEL];
   assign refSeg = segOf(refKind, refBase, refOverride, refOverSeg);

   arf_flag_unit flagUnit (
      .sub(aluSub),
      .size(aluSize),
      .a(aluA),
      .b(aluB),
      .cin(aluUseCarry & s.flags[`ARF_F_CF]),
      .res(aluRes),
      .flagVal(aluFlags)
   );

   arf_seg_unit segUnit (
      .realStyle(realStyle),
      .pe(s.pe),
      .pg(s.pg),
      .addr32(refAddr32),
      .sel(s.sel[refSeg]),
      .base(s.base[refSeg]),
      .offset(refOffset),
      .loadSel(segLoadSel),
      .linAddr(segLin),
      .xlate(segXlate),
      .descIndex(descIndex),
      .descLocal(descLocal),
      .reqPriv(loadRpl)
   );

   // Next state; later updates win, so hardware events override bus writes
   always_comb begin
      logic [31:0] popMask;
      logic [2:0] slot;
      popMask = `ARF_FLAGS_SW;
      slot = slotOf(gprWrIdx, gprWrSize);
      next_s = s;
      next_s.stepTrap = 1'b0;
      next_s.intrAck = 1'b0;
      next_s.debugFault = 1'b0;
      next_s.ioDeny = ioCheck & s.pe & (s.current_privilege > io_privilege_level);
      next_s.privFault = privOp & s.pe & s.flags[`ARF_F_VM];
      // Bus read data is captured in the setup phase
      if (psel && !penable) begin
         case (paddr)
            `ARF_OFF_FLAGS: next_s.prdata = s.flags;
            `ARF_OFF_IP: next_s.prdata = s.ip;
            `ARF_OFF_CTRL: begin
               next_s.prdata = `ARF_ZERO32;
               next_s.prdata[`ARF_C_PE] = s.pe;
               next_s.prdata[`ARF_C_PG] = s.pg;
               next_s.prdata[`ARF_C_AM] = s.am;
               next_s.prdata[`ARF_C_CPL] = s.current_privilege;
            end
            `ARF_OFF_STAT: begin
               next_s.prdata = `ARF_ZERO32;
               next_s.prdata[`ARF_S_EPL] = s.effective_privilege;
               next_s.prdata[`ARF_S_ARM] = (s.run == RUN_ARMED);
            end
            default: begin
               if (paddr[7:5] == `ARF_GPR_PAGE) begin
                  next_s.prdata = s.gpr[paddr[4:2]];
               end else if (mapped(paddr)) begin
                  next_s.prdata = 32'(s.sel[paddr[4:2]]);
               end else begin
                  next_s.prdata = `ARF_ZERO32;
               end
            end
         endcase
      end
      // Bus writes; selectors are read-only since loads need a descriptor
      if (psel && penable && pwrite) begin
         case (paddr)
            `ARF_OFF_FLAGS: begin
               next_s.flags = (s.flags & ~`ARF_FLAGS_SW) | (pwdata & `ARF_FLAGS_SW);
            end
            `ARF_OFF_IP: next_s.ip = pwdata;
            `ARF_OFF_CTRL: begin
               next_s.pe = pwdata[`ARF_C_PE];
               next_s.pg = pwdata[`ARF_C_PG];
               next_s.am = pwdata[`ARF_C_AM];
               next_s.current_privilege = pwdata[`ARF_C_CPL];
            end
            default: begin
               if (paddr[7:5] == `ARF_GPR_PAGE) begin
                  next_s.gpr[paddr[4:2]] = pwdata;
               end
            end
         endcase
      end
      // Registered read port
      next_s.rdData = pickOut(s.gpr[slotOf(gprRdIdx, gprRdSize)],
                              laneOf(gprRdIdx, gprRdSize));
      if (gprWrEn) begin
         next_s.gpr[slot] = mergeIn(s.gpr[slot], gprWrData,
                                    laneOf(gprWrIdx, gprWrSize));
      end
      // Arithmetic writes its result and all six status flags
      if (aluValid) begin
         next_s.gpr[slotOf(aluDst, aluSize)] = mergeIn(s.gpr[slotOf(aluDst, aluSize)],
                                                      aluRes, laneOf(aluDst, aluSize));
         next_s.flags = (next_s.flags & ~`ARF_FLAGS_ARITH)
            | aluFlags;
      end
      // String index stepping
      if (strStep) begin
         if (s.flags[`ARF_F_DF]) begin
            next_s.gpr[`ARF_SI] = next_s.gpr[`ARF_SI] - stepOf(strSize);
            next_s.gpr[`ARF_DI] = next_s.gpr[`ARF_DI] - stepOf(strSize);
         end else begin
            next_s.gpr[`ARF_SI] = next_s.gpr[`ARF_SI] + stepOf(strSize);
            next_s.gpr[`ARF_DI] = next_s.gpr[`ARF_DI] + stepOf(strSize);
         end
      end
      // Segment load fills the hidden cache once
      if (segLoad) begin
         next_s.sel[segLoadIdx] = segLoadSel;
         next_s.effective_privilege = (loadRpl > s.current_privilege) ? loadRpl : s.current_privilege;
         if (realStyle) begin
            next_s.base[segLoadIdx] = 32'(segLoadSel) << `ARF_SEG_SHIFT;
            next_s.lim[segLoadIdx] = `ARF_LIM_RST;
         end else begin
            next_s.base[segLoadIdx] = descBase;
            next_s.lim[segLoadIdx] = descLimit;
            next_s.acc[segLoadIdx] = descRights;
         end
      end
      // Address generation result
      if (refValid) begin
         next_s.linAddr = segLin;
         next_s.xlate = segXlate;
         next_s.alignFault = s.flags[`ARF_F_AC] & s.am
            & ((refSize == SZ_W && segLin[0]) || (refSize == SZ_D && segLin[1:0] != 2'h0));
      end else begin
         next_s.alignFault = 1'b0;
      end
      // Flag pops: enable bit and privilege field are guarded
      if (popValid || iretValid) begin
         if (s.pe && s.current_privilege > io_privilege_level) begin
            popMask[`ARF_F_IF] = 1'b0;
         end
         if (s.pe && s.current_privilege != `ARF_PRIV0) begin
            popMask[`ARF_F_IO_PRIVILEGE_LEVEL] = 2'h0;
         end
         if (iretValid && s.pe && s.current_privilege == `ARF_PRIV0) begin
            popMask[`ARF_F_VM] = 1'b1;
         end
         next_s.flags = (next_s.flags & ~popMask) | (popData & popMask);
      end
      if (taskSwitch) begin
         next_s.flags = taskFlags;
         next_s.flags[`ARF_F_NT] = taskNested | taskFlags[`ARF_F_NT];
      end
      // Instruction boundary: pointer, trap, interrupt, debug
      if (retire) begin
         next_s.debugFault = debugReq & ~s.flags[`ARF_F_RF];
         next_s.flags[`ARF_F_RF] = 1'b0;
         if (vecLoad) begin
            next_s.ip = vecTarget;
         end else if (branch) begin
            next_s.ip = branchTarget;
         end else begin
            next_s.ip = s.ip + 32'(instrLen);
         end
         next_s.intrAck = intrReq & s.flags[`ARF_F_IF] & ~vecLoad;
         // Trap fires on the retire after the one that sees the flag set, whether or not the flag is still set; that first retire only arms it
         case (s.run)
            RUN_IDLE: begin
               if (s.flags[`ARF_F_TF]) begin
                  next_s.run = RUN_ARMED;
               end
            end
            RUN_ARMED: begin
               next_s.stepTrap = 1'b1;
               next_s.flags[`ARF_F_TF] = 1'b0;
               next_s.run = RUN_IDLE;
            end
            default: next_s.run = RUN_IDLE;
         endcase
      end else if (vecLoad) begin
         next_s.ip = vecTarget;
      end
      // Reserved bits pinned whatever path wrote the flags
      next_s.flags = (next_s.flags & `ARF_FLAGS_LIVE) | `ARF_FLAGS_ONE;
   end

   // Whole state in one register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.run <= RUN_IDLE;
         s.flags <= `ARF_FLAGS_RST;
         s.ip <= `ARF_IP_RST;
         s.sel[SEG_CODE] <= `ARF_CS_RST;
         s.lim <= {6{`ARF_LIM_RST}};
      end else begin
         s <= next_s;
      end
   end

   // Zero-wait slave: read data was latched in setup
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped(paddr);
   assign prdata = s.prdata;
   assign gprRdData = s.rdData;
   assign linAddr = s.linAddr;
   assign linXlate = s.xlate;
   assign alignFault = s.alignFault;
   assign intrAck = s.intrAck;
   assign stepTrap = s.stepTrap;
   assign debugFault = s.debugFault;
   assign ioDeny = s.ioDeny;
   assign privFault = s.privFault;
   assign flags = s.flags;
   assign ip = s.ip;
   assign effPriv = s.effective_privilege;
endmodule // arf_register_file
`default_nettype wire

// file: verification/arf_monitor.sv
`default_nettype none
module arf_monitor (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic aluValid,
   input wire logic aluSub,
   input wire arf_pkg::arf_size_t aluSize,
   input wire logic [31:0] aluA,
   input wire logic [31:0] aluB,
   input wire logic aluUseCarry,
   input wire logic popValid,
   input wire logic iretValid,
   input wire logic taskSwitch,
   input wire logic retire,
   input wire logic [3:0] instrLen,
   input wire logic branch,
   input wire logic [31:0] branchTarget,
   input wire logic vecLoad,
   input wire logic [15:0] segLoadSel,
   input wire logic [12:0] descIndex,
   input wire logic descLocal,
   input wire logic refValid,
   input wire logic alignFault,
   input wire logic intrAck,
   input wire logic stepTrap,
   input wire logic debugFault,
   input wire logic [31:0] flags,
   input wire logic [31:0] ip
);
   import arf_pkg::*;
   logic [32:0] sum;
   logic addOk;
   wire logic ipWr = psel && penable && pwrite && paddr == 8'h04;
   // Plain dword add seen last cycle; excludes writers that outrank the adder
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sum <= '0;
         addOk <= 1'b0;
      end else begin
         sum <= {1'b0, aluA} + {1'b0, aluB};
         addOk <= aluValid && !aluSub && !aluUseCarry && aluSize == SZ_D && !popValid
            && !iretValid && !taskSwitch;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Fixed flag bits, then flag results against an independent sum
   a_flags_fixed: assert property (flags[1] && (flags & 32'hFFF8_8028) == '0)
      else $error("reserved flag bits wrong");
   a_carry_out: assert property (addOk |-> flags[0] == sum[32])
      else $error("carry flag wrong");
   a_parity_low: assert property (addOk |-> flags[2] == ~^sum[7:0])
      else $error("parity flag wrong");
   a_zero_sign: assert property (addOk |-> flags[6] == (sum[31:0] == '0)
      && flags[7] == sum[31])
      else $error("zero or sign flag wrong");
   // Pointer movement, selector decode and event gating
   a_ip_advance: assert property (retire && !branch && !vecLoad && !ipWr
      |=> ip == $past(ip) + $past(instrLen))
      else $error("pointer did not advance");
   a_ip_branch: assert property (retire && branch && !vecLoad && !ipWr
      |=> ip == $past(branchTarget))
      else $error("pointer missed jump");
   a_sel_fields: assert property (descIndex == segLoadSel[15:3]
      && descLocal == segLoadSel[2])
      else $error("selector decode wrong");
   a_align_cause: assert property (alignFault |-> $past(refValid) && $past(flags[18]))
      else $error("alignment fault without cause");
   a_maskable_interrupt_input_enable: assert property (intrAck |-> $past(flags[9]))
      else $error("interrupt taken while masked");
   a_step_clear: assert property (stepTrap |-> !flags[8])
      else $error("step flag not cleared");
   a_resume_mask: assert property (debugFault |-> !$past(flags[16]))
      else $error("debug fault not suppressed");
endmodule // arf_monitor
bind arf_register_file arf_monitor i_mon (.*);
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import arf_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, e, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = '0, prdata, gprWrData = '0, gprRdData, aluA = '0, aluB = '0, q;
   logic [31:0] descBase = '0, descLimit = '0, refOffset = '0, linAddr, branchTarget = '0;
   logic [31:0] vecTarget = '0, popData = '0, taskFlags = '0, flags, ip;
   logic gprWrEn = 0, aluValid = 0, aluSub = 0, aluUseCarry = 0, strStep = 0, segLoad = 0;
   logic descLocal, refValid = 0, refOverride = 0, refAddr32 = 1, linXlate, alignFault;
   logic retire = 0, branch = 0, vecLoad = 0, intrReq = 0, intrAck, stepTrap, debugReq = 0;
   logic debugFault, ioCheck = 0, ioDeny, privOp = 0, privFault, popValid = 0, iretValid = 0;
   logic taskSwitch = 0, taskNested = 0;
   logic [2:0] gprWrIdx = 3'h0, gprRdIdx = 3'h0, aluDst = 3'h0, refBase = 3'h5;
   logic [3:0] instrLen = 4'h0;
   logic [7:0] descRights = 8'h00;
   logic [12:0] descIndex;
   logic [15:0] segLoadSel = 16'h0000;
   logic [1:0] effPriv;
   arf_size_t gprWrSize = SZ_D, gprRdSize = SZ_D, aluSize = SZ_D, strSize = SZ_D, refSize = SZ_D;
   arf_seg_t segLoadIdx = SEG_DATA, refOverSeg = SEG_DATA;
   arf_ref_t refKind = REF_DATA;
   logic [31:0] ta[3] = '{32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0000_0000};
   logic [31:0] tf[3] = '{32'h0000_0057, 32'h0000_0896, 32'h0000_0097};
   int mismatches = 0, n_tests = 0;
   arf_register_file i_dut (.*);
   // Clock at 50 MHz
   always #10 clk = ~clk;
   task chk(input string s, input logic [31:0] x, input logic [31:0] y);
      n_tests++;
      if (y !== x) begin
         $display("[ERR] %s exp %h got %h", s, x, y);
         mismatches++;
      end
   endtask
   // Setup then access; an edge first so no signal is driven twice in one step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task strs(input arf_size_t z);
      @(posedge clk);
      strStep <= 1;
      strSize <= z;
      @(posedge clk);
      strStep <= 0;
   endtask
   task refs(input logic ov, input logic [31:0] o, input arf_ref_t k = REF_DATA);
      @(posedge clk);
      {refValid, refOverride, refOffset} <= {1'b1, ov, o};
      refKind <= k;
      @(posedge clk);
      refValid <= 0;
      @(negedge clk);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog, well past the hundred or so cycles the tests need
   initial begin
      #40us;
      mismatches++;
      close_out;
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1;
      apb(0, 8'h00, '0);
      chk("flags", 32'h0000_0002, q);
      apb(0, 8'h04, '0);
      chk("ip", 32'h0000_FFF0, q);
      apb(1, 8'h00, 32'h0000_8409);
      apb(0, 8'h00, '0);
      chk("flags wr", 32'h0000_0403, q);
      apb(0, 8'h10, '0);
      chk("slverr", 32'h0000_0001, {31'h0, e});
      // Real mode: base is the selector times sixteen
      @(posedge clk);
      {segLoad, segLoadSel} <= {1'b1, 16'h1234};
      @(posedge clk);
      segLoad <= 0;
      refs(1, 32'h0000_0010);
      chk("real addr", 32'h0001_2350, linAddr);
      $display("test reset and flags done");
      // Direction set: step down, then clear it and step up by a word
      strs(SZ_D);
      apb(0, 8'h38, '0);
      chk("src idx", 32'hFFFF_FFFC, q);
      apb(0, 8'h3C, '0);
      chk("dst idx", 32'hFFFF_FFFC, q);
      apb(1, 8'h00, '0);
      strs(SZ_W);
      apb(0, 8'h38, '0);
      chk("src idx", 32'hFFFF_FFFE, q);
      $display("test string step done");
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         {aluValid, aluSub, aluA, aluB} <= {1'b1, i == 2, ta[i], 32'h0000_0001};
         @(posedge clk);
         aluValid <= 0;
         @(negedge clk);
         chk("alu flags", tf[i], flags);
         apb(0, 8'h20, '0);
         chk("alu result", i == 2 ? ta[i] - 1 : ta[i] + 1, q);
      end
      @(posedge clk);
      {gprWrEn, gprWrIdx, gprWrData} <= {1'b1, 3'h4, 32'h0000_00AB};
      gprWrSize <= SZ_BLO;
      @(posedge clk);
      {gprWrEn, gprRdIdx} <= 4'h4;
      gprRdSize <= SZ_BLO;
      apb(0, 8'h20, '0);
      chk("high byte", 32'hFFFF_ABFF, q);
      chk("rd port", 32'h0000_00AB, gprRdData);
      $display("test alu done");
      // Two retires back to back, the second a jump
      @(posedge clk);
      {retire, instrLen, intrReq} <= {1'b1, 4'h3, 1'b1};
      @(posedge clk);
      {branch, branchTarget} <= {1'b1, 32'h0000_1234};
      @(negedge clk);
      chk("ip step", 32'h0000_FFF3, ip);
      chk("maskable_interrupt_input masked", 0, intrAck);
      @(posedge clk);
      {retire, branch} <= 2'b00;
      @(negedge clk);
      chk("ip jump", 32'h0000_1234, ip);
      // Trap, enable and resume set: first retire arms, second traps
      apb(1, 8'h00, 32'h0001_0300);
      @(posedge clk);
      {retire, debugReq} <= 2'b11;
      @(posedge clk);
      @(negedge clk);
      chk("maskable_interrupt_input ack", 1, intrAck);
      chk("rf mask", 0, debugFault);
      @(posedge clk);
      {retire, debugReq} <= 2'b00;
      @(negedge clk);
      chk("step trap", 1, stepTrap);
      chk("tf clear", 0, flags[8]);
      chk("debug", 1, debugFault);
      $display("test pointer done");
      apb(1, 8'h08, 32'h0000_0021);
      for (int r = 0; r < 4; r++) begin
         @(posedge clk);
         {segLoad, segLoadSel, descBase} <= {1'b1, 13'h0003, 1'b1, r[1:0], 32'h0001_0000};
         @(posedge clk);
         {segLoad, ioCheck, privOp} <= 3'b011;
         @(negedge clk);
         chk("eff priv", r < 2 ? 2 : r, {30'h0, effPriv});
      end
      // Frame pointer base defaults to the stack segment, base zero
      refs(0, 32'h0000_0010);
      chk("frame seg", 32'h0000_0010, linAddr);
      chk("io deny", 1, ioDeny);
      chk("priv op", 0, privFault);
      refs(1, 32'h0000_0010);
      chk("lin addr", 32'h0001_0010, linAddr);
      refs(1, 32'h0000_0010, REF_STACK);
      chk("no override", 32'h0000_0010, linAddr);
      // Pop at privilege 2 keeps the enable bit; task switch nests
      @(posedge clk);
      popValid <= 1;
      @(posedge clk);
      {popValid, taskSwitch, taskNested} <= 3'b011;
      @(negedge clk);
      chk("pop guard", 32'h0000_0202, flags);
      @(posedge clk);
      taskSwitch <= 0;
      @(negedge clk);
      chk("nested", 32'h0000_4002, flags);
      $display("test segment done");
      apb(1, 8'h00, 32'h0004_0000);
      refs(0, 32'h0000_0001);
      chk("no mask", 32'h0000_0000, {31'h0, alignFault});
      apb(1, 8'h08, 32'h0000_0027);
      refs(0, 32'h0000_0001);
      chk("align", 32'h0000_0001, {31'h0, alignFault});
      chk("xlate", 1, linXlate);
      $display("test alignment done");
      close_out;
   end
endmodule // testbench
`default_nettype wire
